// ==== pkg/kat_regs.svh ====
`ifndef KAT_REGS_SVH
`define KAT_REGS_SVH

// Register offsets (byte addresses, one word each)
`define KAT_CFG_OFS 8'h00
`define KAT_TRIGEN_OFS 8'h04
`define KAT_STATUS_OFS 8'h08
`define KAT_EVENT_OFS 8'h0C

// Configuration field positions
`define KAT_CFG_PART_LSB 0
`define KAT_CFG_LOOPTYPE_LSB 8
`define KAT_CFG_TAMPTYPE_LSB 12
`define KAT_CFG_OCREP_BIT 16

// Reset values
`define KAT_CFG_PART_RST 4'h0
`define KAT_CFG_LOOPTYPE_RST 4'h0
`define KAT_CFG_TAMPTYPE_RST 4'h5
`define KAT_CFG_OCREP_RST 1'b0
`define KAT_TRIGEN_RST 8'h00

// Fixed codes
`define KAT_DAYNIGHT_TYPE 4'h5
`define KAT_KEYSW_USER 8'h00
`define KAT_PART_MAX 4'h8

// Timing: figures in ms, counts derived from the clock rate
`define KAT_CLK_HZ 20000000
`define KAT_HOLD_MS 10000
`define KAT_DEB_MS 20
`define KAT_SLOW_MS 500
`define KAT_RAPID_MS 125
`define KAT_DURESS_MS 1000
`define KAT_HOLD_CYC (`KAT_HOLD_MS * (`KAT_CLK_HZ / 1000))
`define KAT_DEB_CYC (`KAT_DEB_MS * (`KAT_CLK_HZ / 1000))
`define KAT_SLOW_CYC (`KAT_SLOW_MS * (`KAT_CLK_HZ / 1000))
`define KAT_RAPID_CYC (`KAT_RAPID_MS * (`KAT_CLK_HZ / 1000))
`define KAT_DURESS_CYC (`KAT_DURESS_MS * (`KAT_CLK_HZ / 1000))

`endif

// ==== pkg/kat_pkg.sv ====
package kat_pkg;
   // Keyswitch closure tracking
   typedef enum logic [1:0] {
      KAT_IDLE,
      KAT_HELD,
      KAT_WAIT
   } kat_key_state_t;
endpackage

// ==== hdl/kat_debounce.sv ====
module kat_debounce #(
   parameter int unsigned CYC = 4
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Pin and filtered level
   input wire logic rawIn,
   output logic cleanOut
);
   logic sync1_r;
   logic sync2_r;
   logic [31:0] cnt_r;

   // Two stages before anything reads the pin
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= rawIn;
         sync2_r <= sync1_r;
      end
   end

   // Level must stay changed for CYC cycles; bounce restarts the count
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_r <= 32'h0;
         cleanOut <= 1'b0;
      end else if (sync2_r == cleanOut) begin
         cnt_r <= 32'h0;
      end else if (cnt_r >= CYC - 1) begin
         cnt_r <= 32'h0;
         cleanOut <= sync2_r;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
endmodule

// ==== hdl/kat_flasher.sv ====
module kat_flasher #(
   parameter int unsigned HALF = 4
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Square wave, HALF cycles per phase
   output logic phase
);
   logic [31:0] cnt_r;

   // Free running; LEDs need no phase alignment
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_r <= 32'h0;
         phase <= 1'b0;
      end else if (cnt_r >= HALF - 1) begin
         cnt_r <= 32'h0;
         phase <= ~phase;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
endmodule

// ==== hdl/kat_top.sv ====
// How it works
// R01 - Brief closure when disarmed arms full mode
// R02 - Hold over ten seconds arms perimeter mode
// R03 - Closure while armed, no alarm, disarms
// R04 - Never arm while a zone is faulted
// R05 - Closure during alarm silences, disarms if armed
// R06 - Next closure clears memory, resets detectors
// R07 - LEDs encode ready, full and perimeter arming
// R08 - Alarm memory: green off, red rapid flash
// R09 - Tamper raises event, locks keyswitch until disarm
// R10 - Tamper zone uses day-trouble/night-alarm type
// R11 - Keyswitch bound to one partition, 1 to 8
// R12 - Loop zone needs non-zero type to work
// R13 - Keyswitch open/close reports use user zero
// R14 - Triggers shared, gated by per-partition enable
// R15 - Open/close trigger low when all armed
// R16 - Alarm triggers idle low, high on condition
// R17 - Fire, burglary latch until each partition disarms
// R18 - Silent panic latches, duress gives short pulse
// R19 - Triggers only work with keyswitch disabled
// R20 - Loop debounced; long action fires at threshold
// R21 - Duress width and flash rates are parameters
// R22 - Keyswitch acts on burglary of one partition
//
// The implementer's own choices: the address-and-strobe port and the address map.
`include "kat_regs.svh"

module kat_top
   import kat_pkg::*;
#(
   parameter int unsigned HOLD_CYC = `KAT_HOLD_CYC,
   parameter int unsigned DEB_CYC = `KAT_DEB_CYC,
   parameter int unsigned SLOW_HALF = `KAT_SLOW_CYC,
   parameter int unsigned RAPID_HALF = `KAT_RAPID_CYC,
   parameter int unsigned DURESS_CYC = `KAT_DURESS_CYC
) (
   // System
   input wire logic clk_sys,
   input wire logic reset,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [31:0] rdData,
   // Keyswitch pins
   input wire logic keyLoop,
   input wire logic tamperOpen,
   output logic ledGreen,
   output logic ledRed,
   // Panel state, one bit per partition
   input wire logic [7:0] partArmed,
   input wire logic [7:0] partPerim,
   input wire logic [7:0] partAlarm,
   input wire logic [7:0] partReady,
   input wire logic [7:0] partFire,
   input wire logic [7:0] partBurg,
   input wire logic [7:0] partSilent,
   input wire logic [7:0] partDuress,
   input wire logic [7:0] partDisarm,
   // Keyswitch commands to the panel
   output logic armFullReq,
   output logic armPerimReq,
   output logic disarmReq,
   output logic silenceReq,
   output logic memClearReq,
   output logic smokeResetReq,
   output logic [3:0] cmdPart,
   output logic tamperAlarm,
   output logic tamperTrouble,
   // Open/close report
   output logic ocEvent,
   output logic ocArm,
   output logic [7:0] ocUser,
   // Trigger connector
   output logic trigOpenClose,
   output logic trigFire,
   output logic trigBurg,
   output logic trigSilent
);
   logic [3:0] cfgPart_r;
   logic [3:0] loopType_r;
   logic [3:0] tamperType_r;
   logic ocRepEn_r;
   logic [7:0] trigEn_r;
   kat_key_state_t keyState_r;
   kat_key_state_t keyState_nxt;
   logic [31:0] holdCnt_r;
   logic loopClean;
   logic tamperClean;
   logic tamperPrev_r;
   logic slowPhase;
   logic rapidPhase;
   logic lockout_r;
   logic alarmMem_r;
   logic silenced_r;
   logic [7:0] fireL_r;
   logic [7:0] burgL_r;
   logic [7:0] silL_r;
   logic [31:0] duressCnt_r;
   logic [2:0] ksIdx;
   logic partValid;
   logic ksEnable;
   logic trigEnable;
   logic [7:0] trigMask;
   logic ksArmed;
   logic ksPerim;
   logic ksReady;
   logic alarmNow;
   logic doBrief;
   logic doLong;
   logic press;
   logic actSilence;
   logic actClear;
   logic normal;
   logic actDisarm;
   logic actFull;
   logic actPerim;
   logic tamperRise;
   logic duressHit;

   // Filtered loop and tamper, both through the same debounce
   kat_debounce #(.CYC(DEB_CYC)) u_loop (
      .clk_sys(clk_sys),
      .reset(reset),
      .rawIn(keyLoop),
      .cleanOut(loopClean)
   );

   kat_debounce #(.CYC(DEB_CYC)) u_tamper (
      .clk_sys(clk_sys),
      .reset(reset),
      .rawIn(tamperOpen),
      .cleanOut(tamperClean)
   );

   // Flash rates for the red LED
   kat_flasher #(.HALF(SLOW_HALF)) u_slow (
      .clk_sys(clk_sys),
      .reset(reset),
      .phase(slowPhase)
   ); // R21

   kat_flasher #(.HALF(RAPID_HALF)) u_rapid (
      .clk_sys(clk_sys),
      .reset(reset),
      .phase(rapidPhase)
   ); // R21

   // Configuration writes
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cfgPart_r <= `KAT_CFG_PART_RST;
         loopType_r <= `KAT_CFG_LOOPTYPE_RST;
         tamperType_r <= `KAT_CFG_TAMPTYPE_RST;
         ocRepEn_r <= `KAT_CFG_OCREP_RST;
         trigEn_r <= `KAT_TRIGEN_RST;
      end else if (wrStrobe) begin
         if (addr == `KAT_CFG_OFS) begin
            cfgPart_r <= wrData[`KAT_CFG_PART_LSB +: 4];
            loopType_r <= wrData[`KAT_CFG_LOOPTYPE_LSB +: 4];
            tamperType_r <= wrData[`KAT_CFG_TAMPTYPE_LSB +: 4];
            ocRepEn_r <= wrData[`KAT_CFG_OCREP_BIT];
         end
         if (addr == `KAT_TRIGEN_OFS) begin
            trigEn_r <= wrData[7:0];
         end
      end
   end

   // Partition binding; out-of-range numbers disable the keyswitch
   assign partValid = (cfgPart_r != 4'h0) && (cfgPart_r <= `KAT_PART_MAX); // R11
   assign ksIdx = 3'(cfgPart_r - 4'h1);
   assign ksEnable = partValid && (loopType_r != 4'h0); // R12
   assign trigEnable = (cfgPart_r == 4'h0); // R19
   assign trigMask = trigEn_r & {8{trigEnable}}; // R14
   assign ksArmed = partArmed[ksIdx];
   assign ksPerim = partPerim[ksIdx];
   assign ksReady = partReady[ksIdx];
   assign alarmNow = partValid && partAlarm[ksIdx];
   assign cmdPart = cfgPart_r; // R22

   // Closure timing: release before threshold is brief
   always_comb begin
      keyState_nxt = keyState_r;
      doBrief = 1'b0;
      doLong = 1'b0;
      case (keyState_r)
         KAT_IDLE: begin
            if (loopClean) begin
               keyState_nxt = KAT_HELD;
            end
         end
         KAT_HELD: begin
            if (!loopClean) begin
               doBrief = 1'b1; // R20
               keyState_nxt = KAT_IDLE;
            end else if (holdCnt_r >= HOLD_CYC - 1) begin
               doLong = 1'b1; // R20
               keyState_nxt = KAT_WAIT;
            end
         end
         KAT_WAIT: begin
            if (!loopClean) begin
               keyState_nxt = KAT_IDLE;
            end
         end
         default: begin
            keyState_nxt = KAT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         keyState_r <= KAT_IDLE;
         holdCnt_r <= 32'h0;
      end else begin
         keyState_r <= keyState_nxt;
         holdCnt_r <= (keyState_r == KAT_HELD) ? holdCnt_r + 32'h1 : 32'h0;
      end
   end

   // Action decode; a long hold outside the disarmed idle case acts as brief
   assign press = (doBrief || doLong) && ksEnable && !lockout_r; // R09
   assign actSilence = press && alarmNow; // R05
   assign actClear = press && !alarmNow && silenced_r; // R06
   assign normal = press && !alarmNow && !silenced_r;
   assign actDisarm = (actSilence || normal) && ksArmed; // R03
   assign actFull = normal && !ksArmed && ksReady && doBrief; // R01 R04
   assign actPerim = normal && !ksArmed && ksReady && doLong; // R02 R04

   // Command pulses, one cycle each
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         armFullReq <= 1'b0;
         armPerimReq <= 1'b0;
         disarmReq <= 1'b0;
         silenceReq <= 1'b0;
         memClearReq <= 1'b0;
         smokeResetReq <= 1'b0;
      end else begin
         armFullReq <= actFull; // R01
         armPerimReq <= actPerim; // R02
         disarmReq <= actDisarm; // R03
         silenceReq <= actSilence; // R05
         memClearReq <= actClear; // R06
         smokeResetReq <= actClear; // R06
      end
   end

   // Alarm memory and silenced stage; a fresh alarm beats a clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         alarmMem_r <= 1'b0;
         silenced_r <= 1'b0;
      end else begin
         alarmMem_r <= alarmNow || (alarmMem_r && !actClear); // R08
         silenced_r <= actSilence || (silenced_r && !actClear); // R06
      end
   end

   // Tamper opening: event by zone type, then lockout until keypad disarm
   assign tamperRise = tamperClean && !tamperPrev_r;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tamperPrev_r <= 1'b0;
         tamperAlarm <= 1'b0;
         tamperTrouble <= 1'b0;
         lockout_r <= 1'b0;
      end else begin
         tamperPrev_r <= tamperClean;
         if (tamperType_r == `KAT_DAYNIGHT_TYPE) begin
            tamperAlarm <= tamperRise && ksArmed; // R10
            tamperTrouble <= tamperRise && !ksArmed; // R10
         end else begin
            tamperAlarm <= tamperRise && (tamperType_r != 4'h0); // R09
            tamperTrouble <= 1'b0;
         end
         // Set wins over a same-cycle keypad disarm
         lockout_r <= (tamperRise && ksEnable) || (lockout_r && !(partValid && partDisarm[ksIdx])); // R09
      end
   end

   // Open/close report, always as user zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ocEvent <= 1'b0;
         ocArm <= 1'b0;
         ocUser <= `KAT_KEYSW_USER;
      end else begin
         ocEvent <= ocRepEn_r && (actFull || actPerim || actDisarm); // R13
         if (actFull || actPerim || actDisarm) begin
            ocArm <= actFull || actPerim;
         end
         ocUser <= `KAT_KEYSW_USER; // R13
      end
   end

   // Status LEDs; memory overrides arming display
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ledGreen <= 1'b0;
         ledRed <= 1'b0;
      end else if (!ksEnable) begin
         ledGreen <= 1'b0;
         ledRed <= 1'b0;
      end else if (alarmMem_r) begin
         ledGreen <= 1'b0; // R08
         ledRed <= rapidPhase; // R08
      end else if (ksArmed) begin
         ledGreen <= 1'b0;
         ledRed <= ksPerim ? slowPhase : 1'b1; // R07
      end else begin
         ledGreen <= ksReady; // R07
         ledRed <= 1'b0;
      end
   end

   // Per-partition latches: condition sets, keypad disarm clears, set wins
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fireL_r <= 8'h00;
         burgL_r <= 8'h00;
         silL_r <= 8'h00;
      end else begin
         fireL_r <= partFire | (fireL_r & ~partDisarm); // R17
         burgL_r <= partBurg | (burgL_r & ~partDisarm); // R17
         silL_r <= partSilent | (silL_r & ~partDisarm); // R18
      end
   end

   // Duress only stretches to a fixed pulse, never latched
   assign duressHit = |(partDuress & trigMask);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         duressCnt_r <= 32'h0;
      end else if (duressHit) begin
         duressCnt_r <= DURESS_CYC; // R18
      end else if (duressCnt_r != 32'h0) begin
         duressCnt_r <= duressCnt_r - 32'h1;
      end
   end

   // Trigger outputs, ORed over enabled partitions
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         trigOpenClose <= 1'b0;
         trigFire <= 1'b0;
         trigBurg <= 1'b0;
         trigSilent <= 1'b0;
      end else begin
         trigOpenClose <= |(~partArmed & trigMask); // R15
         trigFire <= |(fireL_r & trigMask); // R16
         trigBurg <= |(burgL_r & trigMask); // R16
         trigSilent <= |(silL_r & trigMask) || (duressCnt_r != 32'h0); // R16 R18
      end
   end

   // Register reads; unmapped offsets answer zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdData <= 32'h0;
      end else if (rdStrobe) begin
         case (addr)
            `KAT_CFG_OFS: rdData <= {15'h0, ocRepEn_r, tamperType_r, loopType_r, 4'h0, cfgPart_r};
            `KAT_TRIGEN_OFS: rdData <= {24'h0, trigEn_r};
            `KAT_STATUS_OFS: rdData <= {20'h0, trigSilent, trigBurg, trigFire, trigOpenClose,
               1'b0, loopClean, trigEnable, ksEnable, 1'b0, silenced_r, alarmMem_r, lockout_r};
            `KAT_EVENT_OFS: rdData <= {23'h0, ocArm, ocUser};
            default: rdData <= 32'h0;
         endcase
      end else begin
         rdData <= 32'h0;
      end
   end

   // Checks
   sequence sAlarmPress;
      press && alarmNow;
   endsequence

   sequence sSilenceOut;
      silenceReq ##0 (disarmReq == $past(ksArmed));
   endsequence

   chk_full_arm: assert property (@(posedge clk_sys) disable iff (reset) // R01
      (doBrief && normal && !ksArmed && ksReady) |=> armFullReq && !armPerimReq)
      else $error("brief closure did not arm full mode");
   chk_perim_arm: assert property (@(posedge clk_sys) disable iff (reset) // R02
      (doLong && normal && !ksArmed && ksReady) |=> armPerimReq && !armFullReq)
      else $error("long hold did not arm perimeter mode");
   chk_armed_disarm: assert property (@(posedge clk_sys) disable iff (reset) // R03
      (normal && ksArmed) |=> disarmReq && !armFullReq)
      else $error("closure while armed did not disarm");
   chk_fault_refuse: assert property (@(posedge clk_sys) disable iff (reset) // R04
      (!ksReady && !ksArmed) |=> !armFullReq && !armPerimReq)
      else $error("armed with a faulted zone");
   chk_alarm_silence: assert property (@(posedge clk_sys) disable iff (reset) // R05
      sAlarmPress |=> sSilenceOut)
      else $error("alarm closure did not silence");
   chk_memory_clear: assert property (@(posedge clk_sys) disable iff (reset) // R06
      actClear |=> memClearReq && smokeResetReq ##1 !silenced_r)
      else $error("memory clear sequence wrong");
   chk_memory_led: assert property (@(posedge clk_sys) disable iff (reset) // R08
      (alarmMem_r && ksEnable) |=> !ledGreen)
      else $error("green on during alarm memory");
   chk_tamper_lock: assert property (@(posedge clk_sys) disable iff (reset) // R09
      (lockout_r && !partDisarm[ksIdx]) |=> lockout_r && !armFullReq && !disarmReq)
      else $error("keyswitch acted while locked");
   chk_oc_user: assert property (@(posedge clk_sys) disable iff (reset) // R13
      (ocRepEn_r && actDisarm) |=> ocEvent && (ocUser == 8'h00))
      else $error("open/close report missing or wrong user");
   chk_trig_off: assert property (@(posedge clk_sys) disable iff (reset) // R19
      (!trigEnable && $past(!trigEnable)) |-> !trigFire && !trigBurg && !trigOpenClose)
      else $error("trigger active with keyswitch enabled");
   chk_duress_pulse: assert property (@(posedge clk_sys) disable iff (reset) // R18
      (duressHit && silL_r == 8'h00 && partSilent == 8'h00) |=> (duressCnt_r == DURESS_CYC) ##1 trigSilent)
      else $error("duress pulse not started");
endmodule

// ==== verification/kat_keyswitch_model.sv ====
module kat_keyswitch_model (
   // System
   input wire logic clk_sys,
   // Contacts: high means loop shorted or case lifted
   output logic keyLoop,
   output logic tamperOpen
);
   timeunit 1ns;
   timeprecision 1ns;

   // Loop rests open and the case fitted, so nothing floats at start
   initial begin
      keyLoop = 1'b0;
      tamperOpen = 1'b0;
   end

   // Turn the key for n clocks then let it spring back; n of 1 acts as a bounce
   task press(input int n);
      @(posedge clk_sys);
      keyLoop <= 1'b1;
      repeat (n) @(posedge clk_sys);
      keyLoop <= 1'b0;
   endtask

   // Case pulled off the wall or refitted
   task lift(input logic v);
      @(posedge clk_sys);
      tamperOpen <= v;
   endtask
endmodule

// ==== verification/keyswitch_alarm_triggers_tb.sv ====
`include "kat_regs.svh"
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module keyswitch_alarm_triggers_tb;
   import kat_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DURESS = 5;
   logic clk_sys = 1'b0;
   logic reset;
   logic [7:0] addr;
   logic [31:0] wrData;
   logic wrStrobe;
   logic rdStrobe;
   logic [31:0] rdData, v;
   logic keyLoop, tamperOpen, ledGreen, ledRed, ocArm;
   logic [7:0] partArmed, partPerim, partAlarm, partReady;
   logic [7:0] partFire, partBurg, partSilent, partDuress;
   logic [7:0] partDisarm, ocUser;
   logic armFullReq, armPerimReq, disarmReq, silenceReq, memClearReq, smokeResetReq;
   logic tamperAlarm, tamperTrouble, ocEvent, trigOpenClose, trigFire, trigBurg, trigSilent;
   logic [3:0] cmdPart;
   logic [8:0] pulse;
   int cnt [9];
   int base [9];
   int mismatches = 0;
   int testsRun = 0;
   int t;

   always #25 clk_sys = ~clk_sys;

   kat_top #(.HOLD_CYC(20), .DEB_CYC(2), .SLOW_HALF(4), .RAPID_HALF(2), .DURESS_CYC(DURESS)) u_dut (
      .clk_sys(clk_sys), .reset(reset), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
      .rdStrobe(rdStrobe), .rdData(rdData), .keyLoop(keyLoop), .tamperOpen(tamperOpen),
      .ledGreen(ledGreen), .ledRed(ledRed), .partArmed(partArmed), .partPerim(partPerim),
      .partAlarm(partAlarm), .partReady(partReady), .partFire(partFire), .partBurg(partBurg),
      .partSilent(partSilent), .partDuress(partDuress), .partDisarm(partDisarm),
      .armFullReq(armFullReq), .armPerimReq(armPerimReq), .disarmReq(disarmReq),
      .silenceReq(silenceReq), .memClearReq(memClearReq), .smokeResetReq(smokeResetReq),
      .cmdPart(cmdPart), .tamperAlarm(tamperAlarm), .tamperTrouble(tamperTrouble),
      .ocEvent(ocEvent), .ocArm(ocArm), .ocUser(ocUser), .trigOpenClose(trigOpenClose),
      .trigFire(trigFire), .trigBurg(trigBurg), .trigSilent(trigSilent));

   kat_keyswitch_model u_key (.clk_sys(clk_sys), .keyLoop(keyLoop), .tamperOpen(tamperOpen));

   // Count every command pulse, so a doubled or missing pulse shows up
   assign pulse = {ocEvent, tamperTrouble, tamperAlarm, smokeResetReq, memClearReq, silenceReq,
                   disarmReq, armPerimReq, armFullReq};
   always @(posedge clk_sys) begin
      for (int i = 0; i < 9; i++) if (pulse[i] === 1'b1) cnt[i] <= cnt[i] + 1;
   end

   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'b1;
      @(posedge clk_sys);
      wrStrobe <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk_sys);
      rdStrobe <= 1'b0;
      #1 d = rdData;
   endtask

   task judge(input logic [8:0] exp);
      tick(12);
      for (int i = 0; i < 9; i++) `CHK(cnt[i] - base[i], int'(exp[i]))
   endtask

   task key(input int n, input logic [8:0] exp);
      base = cnt;
      u_key.press(n);
      judge(exp);
   endtask

   // One-cycle panel event: 0 fire, 1 burglary, 2 silent, 3 duress, else keypad disarm
   task hit(input int k, input logic [7:0] p);
      for (int j = 0; j < 2; j++) begin
         @(posedge clk_sys);
         case (k)
            0: partFire <= p;
            1: partBurg <= p;
            2: partSilent <= p;
            3: partDuress <= p;
            default: partDisarm <= p;
         endcase
         p = 8'h00;
      end
   endtask

   // Edges of the red lamp over a fixed window tell steady, slow and rapid apart
   task flash(output int n);
      logic p;
      n = 0;
      // Let the lamp settle on the new state so the change itself is not counted
      tick(2);
      p = ledRed;
      repeat (24) begin
         tick(1);
         if (ledRed !== p) n++;
         p = ledRed;
      end
   endtask

   task t_regs;
      rd(`KAT_CFG_OFS, v);
      `CHK(v, 32'h0000_5000)
      rd(`KAT_TRIGEN_OFS, v);
      `CHK(v, 32'h0000_0000)
      wr(8'h10, 32'hFFFF_FFFF);
      wr(`KAT_EVENT_OFS, 32'hFFFF_FFFF);
      rd(8'h10, v);
      `CHK(v, 32'h0000_0000)
      wr(`KAT_CFG_OFS, 32'h0001_5701);
      rd(`KAT_CFG_OFS, v);
      `CHK(v, 32'h0001_5701)
      `CHK(cmdPart, 4'h1)
      $display("regs done");
   endtask

   task t_arm;
      `CHK({ledGreen, ledRed}, 2'b10)
      key(1, 9'h000);
      key(8, 9'h101);
      `CHK({ocArm, ocUser}, 9'h100)
      rd(`KAT_EVENT_OFS, v);
      `CHK(v, 32'h0000_0100)
      partArmed <= 8'h01;
      flash(t);
      `CHK({ledGreen, ledRed, 5'(t)}, 7'h20)
      key(8, 9'h104);
      `CHK(ocArm, 1'b0)
      partArmed <= 8'h00;
      key(40, 9'h102);
      partArmed <= 8'h01;
      partPerim <= 8'h01;
      flash(t);
      `CHK(ledGreen === 1'b0 && t >= 4 && t <= 7, 1'b1)
      partArmed <= 8'h00;
      partPerim <= 8'h00;
      partReady <= 8'h00;
      key(8, 9'h000);
      `CHK({ledGreen, ledRed}, 2'b00)
      partReady <= 8'hFF;
      $display("arm done");
   endtask

   task t_alarm;
      partArmed <= 8'h01;
      partAlarm <= 8'h01;
      key(8, 9'h10C);
      rd(`KAT_STATUS_OFS, v);
      `CHK(v, 32'h0000_0016)
      partArmed <= 8'h00;
      partAlarm <= 8'h00;
      flash(t);
      `CHK(ledGreen === 1'b0 && t >= 10, 1'b1)
      key(8, 9'h030);
      `CHK({ledGreen, ledRed}, 2'b10)
      partAlarm <= 8'h01;
      key(8, 9'h008);
      partAlarm <= 8'h00;
      key(8, 9'h030);
      $display("alarm done");
   endtask

   task t_tamper;
      base = cnt;
      u_key.lift(1'b1);
      judge(9'h080);
      u_key.lift(1'b0);
      key(8, 9'h000);
      hit(4, 8'h01);
      key(8, 9'h101);
      partArmed <= 8'h01;
      base = cnt;
      u_key.lift(1'b1);
      judge(9'h040);
      u_key.lift(1'b0);
      key(8, 9'h000);
      hit(4, 8'h01);
      partArmed <= 8'h00;
      $display("tamper done");
   endtask

   task t_disable;
      wr(`KAT_CFG_OFS, 32'h0001_5001);
      key(8, 9'h000);
      wr(`KAT_CFG_OFS, 32'h0001_5709);
      key(8, 9'h000);
      wr(`KAT_CFG_OFS, 32'h0001_5702);
      partReady <= 8'h02;
      key(8, 9'h101);
      `CHK(cmdPart, 4'h2)
      partReady <= 8'hFF;
      $display("disable done");
   endtask

   task t_trig;
      wr(`KAT_CFG_OFS, 32'h0000_5000);
      wr(`KAT_TRIGEN_OFS, 32'h0000_0003);
      partArmed <= 8'h03;
      tick(4);
      `CHK(trigOpenClose, 1'b0)
      partArmed <= 8'h01;
      tick(4);
      `CHK(trigOpenClose, 1'b1)
      partArmed <= 8'h03;
      hit(0, 8'h04);
      tick(4);
      `CHK({trigOpenClose, trigFire}, 2'b00)
      hit(0, 8'h02);
      tick(10);
      `CHK(trigFire, 1'b1)
      hit(4, 8'h02);
      tick(4);
      `CHK(trigFire, 1'b0)
      hit(1, 8'h03);
      hit(4, 8'h01);
      tick(4);
      `CHK(trigBurg, 1'b1)
      hit(4, 8'h02);
      tick(4);
      `CHK(trigBurg, 1'b0)
      hit(2, 8'h01);
      tick(10);
      `CHK(trigSilent, 1'b1)
      hit(4, 8'h01);
      tick(4);
      `CHK(trigSilent, 1'b0)
      hit(3, 8'h01);
      t = 0;
      repeat (20) begin
         tick(1);
         if (trigSilent === 1'b1) t++;
      end
      `CHK(t, DURESS)
      hit(0, 8'h01);
      partArmed <= 8'h00;
      wr(`KAT_CFG_OFS, 32'h0001_5701);
      tick(4);
      `CHK({trigOpenClose, trigFire, trigBurg, trigSilent}, 4'h0)
      $display("trigger done");
   endtask

   task end_sim;
      $display("Comparisons %0d, mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog: a hung scenario counts as a mismatch and ends the run
   initial begin
      repeat (50000) @(posedge clk_sys);
      $display("Run limit reached");
      mismatches++;
      end_sim();
   end

   // Reset for six clocks, then each scenario in turn
   initial begin
      reset <= 1'b1;
      addr <= 8'h00;
      wrData <= 32'h0000_0000;
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      partArmed <= 8'h00;
      partPerim <= 8'h00;
      partAlarm <= 8'h00;
      partReady <= 8'hFF;
      partFire <= 8'h00;
      partBurg <= 8'h00;
      partSilent <= 8'h00;
      partDuress <= 8'h00;
      partDisarm <= 8'h00;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      t_regs();
      t_arm();
      t_alarm();
      t_tamper();
      t_disable();
      t_trig();
      end_sim();
   end
endmodule
